// File: hw/ixru_addr_sel.sv
// ixru_addr_sel: instruction address field selection.
// assumes the instruction fields are stable for the cycle they are used.
`timescale 1ns/1ps
`default_nettype none
module ixru_addr_sel import ixru_pkg::*; (
    input wire logic selFlag,
    input wire logic [NUM_W-1:0] num,
    input wire logic [ADDR_W-1:0] addr,
    output logic [NUM_W-1:0] ixNum,
    output logic [FULL_W-1:0] fullAddr,
    output logic [ADDR_W-1:0] operandAddr
);
    always_comb begin
        ixNum = num;
        fullAddr = {num, addr};
        // reduced field only while select flag set, else full field wrapped
        operandAddr = selFlag ? addr : fullAddr[ADDR_W-1:0];
    end
endmodule
`default_nettype wire

// File: hw/ixru_pkg.sv
// ixru_pkg: constants and carrier types of the index register unit.
// assumes a 12-bit address space of 4096 words and eight index registers.
package ixru_pkg;
    localparam int ADDR_W = 12;
    localparam int NUM_W = 3;
    localparam int NUM_IX = 8;
    localparam int FULL_W = ADDR_W + NUM_W;
    localparam logic [ADDR_W-1:0] ADDR_ONE = 12'h001;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 12'h000;
    localparam logic HALF_LEFT = 1'b0;
    localparam logic HALF_RIGHT = 1'b1;

    typedef enum logic [2:0] {
        IXRU_OP_NONE = 3'h0,
        IXRU_OP_LOAD = 3'h1,
        IXRU_OP_ADD_D = 3'h2,
        IXRU_OP_SUB_D = 3'h3,
        IXRU_OP_ADD_JUMP = 3'h4,
        IXRU_OP_SUB_JUMP = 3'h5,
        IXRU_OP_ADD_OVF = 3'h6,
        IXRU_OP_SUB_OVF = 3'h7
    } ixru_op_t;

    // one half of the operand word register; command field is not carried
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic halfSel;
    } ixru_half_t;

    typedef struct packed {
        ixru_half_t left;
        ixru_half_t right;
    } ixru_dword_t;

    // instruction as presented by the sequencer
    typedef struct packed {
        logic valid;
        ixru_op_t op;
        logic selFlag;
        logic [NUM_W-1:0] num;
        logic [ADDR_W-1:0] addr;
        logic useRight;
        logic counterOpt;
        logic [ADDR_W-1:0] nextAddr;
    } ixru_instr_t;

    typedef struct packed {
        logic done;
        logic jump;
        logic [ADDR_W-1:0] jumpTarget;
        logic [ADDR_W-1:0] jumpAddress;
        logic overflow;
        logic [ADDR_W-1:0] effAddr;
    } ixru_result_t;

    typedef struct packed {
        logic [ADDR_W-1:0] value;
        logic counter;
    } ixru_ix_t;
endpackage

// File: hw/ixru_top.sv
// ixru_top: index register file with loading, arithmetic, counting and loop test.
// assumes a sequencer presents one instruction as a one-cycle valid pulse, with
// the operand word register halves stable in the same cycle.
// Notes on behaviour
// - half select bit zero means left half, one means right half
// - load from left half with counter option copies its half bit to counter
// - command fields of the operand word are ignored, only addresses and half bits
// - index register chosen from the instruction's number field
// - select flag one: operand address is the reduced address field only
// - select flag zero: number field still picks register, full field wrapped to 12 bits is address
// - add-and-jump writes the sum back, then compares with left half address
// - unequal: jump to the right half address
// - equal: no jump, continue with the next sequential instruction
// - referencing a counting register increments it by one, even for a filler, except a filler reference in a cycle with a valid instruction
// - index arithmetic wraps modulo 4096
// - load without counter option leaves the counter indicator unchanged
// - add-and-jump always places next sequential address in the jump address reg
// - add-and-overflow clears overflow first, sets it on equality with chosen half
`timescale 1ns/1ps
`default_nettype none
module ixru_top import ixru_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    input wire ixru_instr_t instr,
    input wire ixru_dword_t operandWord,
    input wire logic refValid,
    input wire logic [NUM_W-1:0] refNum,
    output ixru_result_t result,
    output ixru_ix_t [NUM_IX-1:0] ixView
);
    typedef struct packed {
        ixru_ix_t [NUM_IX-1:0] ix;
        ixru_result_t res;
    } ixru_state_t;

    ixru_state_t state_q;
    ixru_state_t state_d;
    logic [NUM_W-1:0] ixNum;
    logic [FULL_W-1:0] fullAddr;
    logic [ADDR_W-1:0] operandAddr;

    ixru_addr_sel addrSel (
        .selFlag(instr.selFlag),
        .num(instr.num),
        .addr(instr.addr),
        .ixNum(ixNum),
        .fullAddr(fullAddr),
        .operandAddr(operandAddr)
    );

    // pick a half of the operand word; half bit zero is left
    function automatic ixru_half_t pickHalf(input ixru_dword_t w, input logic right);
        pickHalf = (right == HALF_RIGHT) ? w.right : w.left;
    endfunction

    // 12-bit add and subtract wrap naturally at the memory size
    function automatic logic [ADDR_W-1:0] wrapAdd(input logic [ADDR_W-1:0] a,
                                                  input logic [ADDR_W-1:0] b,
                                                  input logic sub);
        wrapAdd = sub ? a - b : a + b;
    endfunction

    // loop-limit ops that decide a jump
    function automatic logic isJumpOp(input ixru_op_t op);
        isJumpOp = (op == IXRU_OP_ADD_JUMP) || (op == IXRU_OP_SUB_JUMP);
    endfunction

    // loop-limit ops that drive the overflow indicator
    function automatic logic isOvfOp(input ixru_op_t op);
        isOvfOp = (op == IXRU_OP_ADD_OVF) || (op == IXRU_OP_SUB_OVF);
    endfunction

    // ops that subtract rather than add
    function automatic logic isSubOp(input ixru_op_t op);
        isSubOp = (op == IXRU_OP_SUB_D) || (op == IXRU_OP_SUB_JUMP)
            || (op == IXRU_OP_SUB_OVF);
    endfunction

    // value of each register after its automatic count step
    logic [ADDR_W-1:0] stepped [NUM_IX];
    genvar gi;
    generate
        for (gi = 0; gi < NUM_IX; gi++) begin : g_step
            assign stepped[gi] = state_q.ix[gi].counter ?
                wrapAdd(state_q.ix[gi].value, ADDR_ONE, 1'b0) :
                state_q.ix[gi].value;
        end
    endgenerate

    always_comb begin
        ixru_half_t half;
        ixru_ix_t cur;
        logic [ADDR_W-1:0] base;
        logic [ADDR_W-1:0] sum;
        logic equal;
        half = pickHalf(operandWord, instr.useRight);
        cur = state_q.ix[ixNum];
        base = stepped[ixNum];
        sum = ADDR_ZERO;
        equal = 1'b0;
        state_d = state_q;
        state_d.res.done = 1'b0;
        state_d.res.jump = 1'b0;
        if (instr.valid) begin
            // count step lands before the op's own effect
            cur.value = base;
            state_d.res.done = 1'b1;
            state_d.res.effAddr = wrapAdd(base, operandAddr, 1'b0);
            case (instr.op)
                IXRU_OP_LOAD: begin
                    cur.value = half.addr;
                    if (instr.counterOpt) begin
                        cur.counter = half.halfSel;
                    end // else counter kept
                end
                IXRU_OP_ADD_D, IXRU_OP_SUB_D: begin
                    cur.value = wrapAdd(base, half.addr, isSubOp(instr.op));
                end
                IXRU_OP_ADD_JUMP, IXRU_OP_SUB_JUMP, IXRU_OP_ADD_OVF, IXRU_OP_SUB_OVF: begin
                    sum = wrapAdd(base, operandAddr, isSubOp(instr.op));
                    cur.value = sum;
                end
                default: begin
                end
            endcase
            if (isJumpOp(instr.op)) begin
                equal = (sum == operandWord.left.addr);
                state_d.res.jump = !equal;
                state_d.res.jumpTarget = operandWord.right.addr;
                state_d.res.jumpAddress = instr.nextAddr;
            end
            if (isOvfOp(instr.op)) begin
                state_d.res.overflow = (sum == half.addr);
            end
            state_d.ix[ixNum] = cur;
        end else if (refValid) begin
            // plain reference by another instruction, e.g. the filler
            state_d.ix[refNum].value = stepped[refNum];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign result = state_q.res;
    assign ixView = state_q.ix;
endmodule
`default_nettype wire

// File: test/ixru_assertions.sv
// ixru_assertions: port checks of the index register unit.
// assumes bind into ixru_top; one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module ixru_assertions import ixru_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    input wire ixru_instr_t instr,
    input wire ixru_dword_t operandWord,
    input wire logic refValid,
    input wire logic [NUM_W-1:0] refNum,
    input wire ixru_result_t result,
    input wire ixru_ix_t [NUM_IX-1:0] ixView
);
    logic [NUM_W-1:0] pn;
    logic [NUM_W-1:0] pr;
    wire logic [ADDR_W-1:0] nv = ixView[pn].value;
    wire logic [ADDR_W-1:0] cv = ixView[instr.num].value;
    wire logic cc = ixView[instr.num].counter;
    always_ff @(posedge clk) begin
        pn <= instr.num;
        pr <= refNum;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_jump; instr.valid && instr.op == IXRU_OP_ADD_JUMP; endsequence
    sequence s_load; instr.valid && instr.op == IXRU_OP_LOAD; endsequence
    a_done_pulse: assert property (instr.valid |=> result.done)
        else $error("done missing");
    a_jump_test: assert property (s_jump |=> result.jump == (nv != $past(operandWord.left.addr)))
        else $error("jump decision wrong");
    a_jump_dest: assert property (s_jump |=> result.jumpTarget == $past(operandWord.right.addr)
        && result.jumpAddress == $past(instr.nextAddr))
        else $error("jump addresses wrong");
    a_add_sum: assert property (s_jump ##0 (instr.selFlag && !cc) |=> nv == $past(cv + instr.addr))
        else $error("sum wrong");
    a_ovf_equal: assert property (instr.valid && instr.op == IXRU_OP_ADD_OVF |=> result.overflow ==
        (nv == $past(instr.useRight ? operandWord.right.addr : operandWord.left.addr)))
        else $error("overflow wrong");
    a_load_count: assert property (s_load ##0 (instr.counterOpt && !instr.useRight) |=>
        ixView[pn].counter == $past(operandWord.left.halfSel)) else $error("counter not copied");
    a_count_kept: assert property (s_load ##0 !instr.counterOpt |=> ixView[pn].counter == $past(cc))
        else $error("counter changed");
    a_ref_step: assert property (refValid && !instr.valid && ixView[refNum].counter |=>
        ixView[pr].value == $past(ixView[refNum].value) + ADDR_ONE) else $error("no count step");
endmodule
bind ixru_top ixru_assertions u_ixru_assertions (.clk(clk), .rst(rst), .instr(instr),
    .operandWord(operandWord), .refValid(refValid), .refNum(refNum), .result(result),
    .ixView(ixView));
`default_nettype wire

// File: test/testbench.sv
// testbench: random instruction stream against a model of the index registers.
// assumes ixru_top and its package; checker attached by bind.
`timescale 1ns/1ps
`default_nettype none
module testbench import ixru_pkg::*;;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic refValid = 1'b0;
    logic [NUM_W-1:0] refNum = '0;
    logic [NUM_W-1:0] n;
    ixru_instr_t instr = '0;
    ixru_dword_t operandWord = '0;
    ixru_result_t result;
    ixru_ix_t [NUM_IX-1:0] ixView;
    logic [ADDR_W-1:0] val [NUM_IX] = '{default: '0};
    logic cnt [NUM_IX] = '{default: 1'b0};
    logic [ADDR_W-1:0] v;
    logic [ADDR_W-1:0] h;
    logic expDone = 1'b0;
    logic expJump;
    logic expOvf;
    logic [ADDR_W-1:0] b;
    logic [ADDR_W-1:0] e;
    int n_errors = 0;
    int cmp_count = 0;
    int seed = 32'h573BCB3A;
    initial begin
        forever #4 clk = ~clk;
    end
    ixru_top u_ixru_top (.clk(clk), .rst(rst), .instr(instr), .operandWord(operandWord),
        .refValid(refValid), .refNum(refNum), .result(result), .ixView(ixView));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // new register value for an op, from the base after the count step
    function automatic logic [ADDR_W-1:0] modelNext(input ixru_op_t op,
        input logic [ADDR_W-1:0] bv, input logic [ADDR_W-1:0] av, input logic [ADDR_W-1:0] hv);
        case (op)
            IXRU_OP_NONE: modelNext = bv;
            IXRU_OP_LOAD: modelNext = hv;
            IXRU_OP_ADD_D: modelNext = bv + hv;
            IXRU_OP_SUB_D: modelNext = bv - hv;
            IXRU_OP_SUB_JUMP, IXRU_OP_SUB_OVF: modelNext = bv - av;
            default: modelNext = bv + av;
        endcase
    endfunction
    task automatic report_and_stop;
        $display("errors=%0d compares=%0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        #1 rst = 1'b0;
        for (int k = 0; k < 3000; k++) begin
            @(posedge clk);
            #1;
            check(result.done, expDone);
            if (expDone)
                check(result.effAddr, e);
            if (expDone && instr.op inside {IXRU_OP_ADD_JUMP, IXRU_OP_SUB_JUMP}) begin
                check({result.jump, result.jumpTarget}, {expJump, operandWord.right.addr});
                check(result.jumpAddress, instr.nextAddr);
            end
            if (expDone && instr.op inside {IXRU_OP_ADD_OVF, IXRU_OP_SUB_OVF})
                check(result.overflow, expOvf);
            for (int j = 0; j < NUM_IX; j++)
                check({ixView[j].counter, ixView[j].value}, {cnt[j], val[j]});
            instr = ixru_instr_t'(34'({$random(seed), $random(seed)}));
            instr.op = ixru_op_t'(3'($random(seed)));
            operandWord = ixru_dword_t'(26'($random(seed)));
            {refValid, refNum} = 4'($random(seed));
            n = instr.num;
            b = val[n] + (cnt[n] ? ADDR_ONE : ADDR_ZERO);
            e = b + instr.addr;
            v = modelNext(instr.op, b, instr.addr, ADDR_ZERO);
            // hit the equal case half the time
            if (seed[0] && instr.op[2]) begin
                operandWord.left.addr = v;
                operandWord.right.addr = v;
            end
            expDone = instr.valid;
            h = instr.useRight ? operandWord.right.addr : operandWord.left.addr;
            expJump = v != operandWord.left.addr;
            expOvf = v == h;
            if (instr.valid) begin
                val[n] = modelNext(instr.op, b, instr.addr, h);
                if (instr.op == IXRU_OP_LOAD && instr.counterOpt)
                    cnt[n] = instr.useRight ? operandWord.right.halfSel : operandWord.left.halfSel;
            end else if (refValid && cnt[refNum])
                val[refNum] = val[refNum] + ADDR_ONE;
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
